// ---- ptm_pkg.sv ----
// Summary of operation
// R01: Eight-bit count register, read/write, reset zero.
// R02: Clock is internal clock over four, prescaled.
// R03: Count up to period, then wrap zero.
// R04: Eight-bit period register, reset to all ones.
// R05: Match feeds postscaler 1..16, output raises interrupt.
// R06: Interrupt flag is bit 1, sticky.
// R07: Timer-on bit 2 clear stops counting.
// R08: Count or control write clears both scalers.
// R09: Control write leaves count unchanged.
// R10: Pre-postscaler match pulse goes to serial port.
// R11: Timer is shared PWM time base.
// R12: Prescale codes: 00 /1, 01 /4, else /16.
// R13: Postscale field bits 6..3, ratio value plus one.
package ptm_pkg;
  // Printed offsets are not all multiples of four: byte address is index times four
  localparam logic [7:0]  IDX_INT_MAIN  = 8'h0b;
  localparam logic [7:0]  IDX_INT_FLAGS = 8'h0c;
  localparam logic [7:0]  IDX_COUNT     = 8'h11;
  localparam logic [7:0]  IDX_CONTROL   = 8'h12;
  localparam logic [7:0]  IDX_INT_ENS   = 8'h8c;
  localparam logic [7:0]  IDX_PERIOD    = 8'h92;
  // Write-one-to-clear register of the interrupt group
  localparam logic [7:0]  IDX_INT_CLEAR = 8'h0d;
  // Reset values
  localparam logic [7:0]  RST_COUNT     = 8'h00;
  localparam logic [7:0]  RST_PERIOD    = 8'hff;
  localparam logic [7:0]  RST_CONTROL   = 8'h00;
  localparam logic [7:0]  RST_FLAGS     = 8'h00;
  // Field positions
  localparam int          BIT_FLAG      = 1;
  localparam int          BIT_ON        = 2;
  localparam int          BIT_PS_LO     = 3;
  localparam int          BIT_MAIN_PEIE = 6;
  localparam int          BIT_MAIN_GIE  = 7;
  localparam logic [6:0]  CTRL_MASK     = 7'h7f;
  // Instruction clock divide
  localparam logic [1:0]  INSTR_DIV_M1  = 2'h3;
endpackage

// ---- ptm_prescale.sv ----
`timescale 1ns/1ns
// Prescaler: passes one of every 1, 4 or 16 instruction ticks
module ptm_prescale (
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_tick,    // Instruction-rate enable
  input  wire logic       i_clear,   // Synchronous clear
  input  wire logic [1:0] i_sel,     // Prescale select
  output logic            o_tick     // Prescaled enable
);
  import ptm_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
  } ptm_ps_t;

  ptm_ps_t s_q;
  ptm_ps_t s_d;
  logic    last;

  // Terminal count from select
  always_comb begin
    case (i_sel)
      2'h0:    last = 1'b1;                    // R12
      2'h1:    last = (s_q.cnt[1:0] == 2'h3);  // R12
      default: last = (s_q.cnt == 4'hf);       // R12
    endcase
  end

  assign o_tick = i_tick & last & ~i_clear;  // R02

  // Counter next state
  always_comb begin
    s_d = s_q;
    if (i_clear) begin
      s_d.cnt = 4'h0;  // R08
    end else if (i_tick) begin
      s_d.cnt = last ? 4'h0 : s_q.cnt + 4'h1;
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  clr_wins_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_clear |=> s_q.cnt == 4'h0) else $error("prescaler not cleared");  // R08
endmodule

// ---- ptm_timer.sv ----
// Register access over APB was decided locally.
`timescale 1ns/1ns
// Period timer with prescaler and postscaler behind an APB slave
module ptm_timer (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  output logic             o_irq,         // Level interrupt
  output logic             o_match_pulse, // Pre-postscale match to serial port
  output logic             o_pwm_period,  // Period event to PWM units
  output logic [7:0]       o_pwm_count    // Shared PWM time base
);
  import ptm_pkg::*;

  typedef struct packed {
    logic [1:0] idiv;     // Instruction clock divider
    logic [7:0] count;    // Timer count
    logic [7:0] period;   // Period
    logic [6:0] control;  // Control fields
    logic [3:0] post;     // Postscale counter
    logic [7:0] flags;    // Sticky flags
    logic [7:0] enables;  // Interrupt enables
    logic [7:0] main;     // Main interrupt control
    logic       match;    // Registered match pulse
    logic [31:0] rdata;   // Read data
  } ptm_st_t;

  ptm_st_t s_q;
  ptm_st_t s_d;

  logic       acc;        // APB access phase
  logic       wr;         // Write strobe
  logic [7:0] idx;        // Register index
  logic       mapped;     // Address decodes
  logic       instr_tick; // Internal clock over four
  logic       pre_tick;   // After prescaler
  logic       scal_clr;   // Clear scalers
  logic       hit;        // Count equals period
  logic       post_out;   // Postscaler output

  assign acc      = i_psel & i_penable;
  assign wr       = acc & i_pwrite;
  assign idx      = i_paddr[9:2];
  assign mapped   = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0) &&
                    (idx == IDX_INT_MAIN || idx == IDX_INT_FLAGS || idx == IDX_COUNT ||
                     idx == IDX_CONTROL || idx == IDX_INT_ENS || idx == IDX_PERIOD ||
                     idx == IDX_INT_CLEAR);
  assign o_pready  = 1'b1;
  assign o_pslverr = acc & ~mapped;
  assign o_prdata  = s_q.rdata;

  assign instr_tick = (s_q.idiv == INSTR_DIV_M1);  // R02
  assign scal_clr   = wr && (idx == IDX_COUNT || idx == IDX_CONTROL);  // R08

  // Prescaler leaf
  ptm_prescale u_pre (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_tick    (instr_tick & s_q.control[BIT_ON]),  // R07
    .i_clear   (scal_clr),
    .i_sel     (s_q.control[1:0]),
    .o_tick    (pre_tick)
  );

  assign hit      = (s_q.count == s_q.period);
  assign post_out = pre_tick & hit &
                    (s_q.post == s_q.control[BIT_PS_LO +: 4]);  // R05 R13

  assign o_match_pulse = s_q.match;  // R10
  assign o_pwm_period  = s_q.match;  // R11
  assign o_pwm_count   = s_q.count;  // R11
  assign o_irq = |(s_q.flags & s_q.enables);

  // Next state of timer and registers
  always_comb begin
    s_d       = s_q;
    s_d.idiv  = s_q.idiv + 2'h1;
    s_d.match = pre_tick & hit;  // R10
    // Count and wrap
    if (pre_tick) begin
      s_d.count = hit ? 8'h00 : s_q.count + 8'h01;  // R03
    end
    // Postscaler
    if (scal_clr) begin
      s_d.post = 4'h0;  // R08
    end else if (pre_tick & hit) begin
      s_d.post = post_out ? 4'h0 : s_q.post + 4'h1;  // R05
    end
    // Register writes
    if (wr && mapped) begin
      case (idx)
        IDX_COUNT:     s_d.count   = i_pwdata[7:0];  // R01
        IDX_CONTROL:   s_d.control = i_pwdata[6:0] & CTRL_MASK;  // R09
        IDX_PERIOD:    s_d.period  = i_pwdata[7:0];  // R04
        IDX_INT_ENS:   s_d.enables = i_pwdata[7:0];
        IDX_INT_MAIN:  s_d.main    = i_pwdata[7:0];
        IDX_INT_FLAGS: s_d.flags   = i_pwdata[7:0];
        IDX_INT_CLEAR: s_d.flags   = s_q.flags & ~i_pwdata[7:0];
        default:       s_d.main    = s_q.main;
      endcase
    end
    // Set wins over clear
    if (post_out) begin
      s_d.flags[BIT_FLAG] = 1'b1;  // R06
    end
    // Read data captured in setup phase
    if (i_psel && !i_penable) begin
      case (idx)
        IDX_COUNT:     s_d.rdata = {24'h0, s_q.count};
        IDX_CONTROL:   s_d.rdata = {25'h0, s_q.control};
        IDX_PERIOD:    s_d.rdata = {24'h0, s_q.period};
        IDX_INT_ENS:   s_d.rdata = {24'h0, s_q.enables};
        IDX_INT_MAIN:  s_d.rdata = {24'h0, s_q.main};
        IDX_INT_FLAGS: s_d.rdata = {24'h0, s_q.flags};
        default:       s_d.rdata = 32'h0;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q         <= '0;
      s_q.count   <= RST_COUNT;   // R01
      s_q.period  <= RST_PERIOD;  // R04
      s_q.control <= RST_CONTROL[6:0];
      s_q.flags   <= RST_FLAGS;
    end else begin
      s_q <= s_d;
    end
  end

  wrap_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (pre_tick && hit && !wr) |=> s_q.count == 8'h00) else $error("no wrap");  // R03
  stop_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!s_q.control[BIT_ON] && !wr) |=> $stable(s_q.count)) else $error("counted while off");  // R07
  flag_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    post_out |=> s_q.flags[BIT_FLAG]) else $error("flag not set");  // R06
  ctrl_keep_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (wr && idx == IDX_CONTROL && !pre_tick) |=> $stable(s_q.count)) else $error("count moved");  // R09
  post_clr_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    scal_clr |=> s_q.post == 4'h0) else $error("postscaler kept");  // R08
  match_out_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (pre_tick && hit) |=> o_match_pulse) else $error("match pulse missing");  // R10
  irq_lvl_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (s_q.flags[BIT_FLAG] && s_q.enables[BIT_FLAG]) |-> o_irq) else $error("irq low");  // R05
  tick_gap_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    instr_tick |=> (!instr_tick) [*3]) else $error("tick too fast");  // R02
endmodule

// ---- period_timer_with_pre_postscale_test.sv ----
`timescale 1ns/1ns
// Compares two values and counts the outcome
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module period_timer_with_pre_postscale_test;
  import ptm_pkg::*;
  logic        i_sys_clk;     // Core clock
  logic        i_resetn;      // Active-low reset
  logic        i_psel;        // APB select
  logic        i_penable;     // APB enable
  logic        i_pwrite;      // APB direction
  logic [11:0] i_paddr;       // APB byte address
  logic [31:0] i_pwdata;      // APB write data
  logic        o_pready;      // APB ready
  logic [31:0] o_prdata;      // APB read data
  logic        o_pslverr;     // APB error
  logic        o_irq;         // Level interrupt
  logic        o_match_pulse; // Serial port shift source
  logic        o_pwm_period;  // PWM period event
  logic [7:0]  o_pwm_count;   // PWM time base
  logic [31:0] rd;            // Last read data
  logic        err;           // Last error response
  logic [7:0]  per;           // Chosen period
  logic [3:0]  ps;            // Chosen postscale
  int          mismatches;    // Failed comparisons
  int          n_checks;      // All comparisons
  int          cyc = 0;       // Free cycle count
  int          t0;            // Pulse time stamps
  int          t1;
  int          n;             // Matches seen
  int          seed = 32'h290b;

  ptm_timer dut_u (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_irq(o_irq),
    .o_match_pulse(o_match_pulse), .o_pwm_period(o_pwm_period), .o_pwm_count(o_pwm_count));

  // Clock at 100 MHz
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // Time base for interval measurement
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
  end

  // Cycles between match pulses for a prescale code and period
  function automatic int interval(int p, logic [7:0] pr);
    return 4 * ((p == 0) ? 1 : (p == 1) ? 4 : 16) * (int'(pr) + 1);
  endfunction

  // Counts and verdict, then stop
  task print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge i_sys_clk);
      if (o_pready === 1'b1) break;
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (k == 16) begin
      mismatches++;
      print_verdict;
    end
  endtask

  // Waits for the next match pulse, bounded
  task wait_match;
    int k;
    for (k = 0; k < 5000; k++) begin
      @(negedge i_sys_clk);
      `CHK(o_pwm_period, o_match_pulse)
      if (o_match_pulse === 1'b1) break;
    end
    if (k == 5000) begin
      mismatches++;
      print_verdict;
    end
  endtask

  initial begin
    {i_resetn, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    repeat (4) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    // Reset values and an unmapped access
    apb(1'b0, 12'h044, 32'h0); `CHK(rd, {24'h0, RST_COUNT})
    apb(1'b0, 12'h248, 32'h0); `CHK(rd, 32'h0000_00ff)
    apb(1'b0, 12'h048, 32'h0); `CHK(rd, 32'h0)
    apb(1'b0, 12'h030, 32'h0); `CHK(rd, 32'h0)
    apb(1'b0, 12'h3fc, 32'h0); `CHK(err, 1'b1)
    // Main interrupt control is stored and reads back
    apb(1'b1, 12'h02c, 32'hc0);
    apb(1'b0, 12'h02c, 32'h0); `CHK(rd, 32'h0000_00c0)
    // Match interval for every prescale code, period zero first
    for (int p = 0; p < 4; p++) begin
      per = (p == 0) ? 8'h00 : 8'($random(seed) & 15);
      apb(1'b1, 12'h048, 32'h0);
      apb(1'b1, 12'h044, 32'h0);
      apb(1'b1, 12'h248, {24'h0, per});
      apb(1'b0, 12'h248, 32'h0); `CHK(rd[7:0], per)
      apb(1'b1, 12'h048, 32'(4 | p));
      wait_match;
      wait_match;
      t0 = cyc;
      wait_match;
      t1 = cyc;
      `CHK(t1 - t0, interval(p, per))
    end
    // Postscaler ratio, flag and interrupt; slowest ratio first
    apb(1'b1, 12'h248, 32'h3);
    apb(1'b1, 12'h230, 32'h2);
    for (int s = 0; s < 3; s++) begin
      ps = (s == 0) ? 4'hf : 4'($random(seed) & 7);
      apb(1'b1, 12'h048, 32'h0);
      apb(1'b1, 12'h044, 32'h0);
      apb(1'b1, 12'h034, 32'h2);
      @(negedge i_sys_clk);
      `CHK(o_irq, 1'b0)
      apb(1'b1, 12'h048, {25'h0, ps, 3'b100});
      n = 0;
      for (int k = 0; k < 400 && o_irq !== 1'b1; k++) begin
        @(negedge i_sys_clk);
        if (o_match_pulse === 1'b1) n++;
      end
      `CHK(n, int'(ps) + 1)
    end
    // Sticky flag, then masking and clearing
    apb(1'b1, 12'h048, 32'h0);
    apb(1'b0, 12'h030, 32'h0); `CHK(rd[1], 1'b1)
    apb(1'b1, 12'h230, 32'h0);
    @(negedge i_sys_clk);
    `CHK(o_irq, 1'b0)
    apb(1'b1, 12'h034, 32'h2);
    apb(1'b0, 12'h030, 32'h0); `CHK(rd[1], 1'b0)
    // Load count, rewrite control while stopped
    apb(1'b1, 12'h044, 32'h5a);
    apb(1'b1, 12'h048, 32'h78);
    apb(1'b0, 12'h044, 32'h0); `CHK(rd, 32'h5a)
    @(negedge i_sys_clk);
    `CHK(o_pwm_count, 8'h5a)
    repeat (50) @(posedge i_sys_clk);
    apb(1'b0, 12'h044, 32'h0); `CHK(rd, 32'h5a)
    print_verdict;
  end
endmodule
